/* psfc_pkg.sv */
// Constants for the power and serial-format configuration bank.
// Assumes one 25 MHz device clock and a two-wire control bus host.

package psfc_pkg;

  // ****************************************
  // Register offsets, resets and write masks
  // ****************************************
  localparam logic [7:0] SLEEP_SUPPLY_OFS    = 8'h02;
  localparam logic [7:0] SHUTDOWN_CHARGE_OFS = 8'h05;
  localparam logic [7:0] SERIAL_FORMAT_OFS   = 8'h07;
  localparam logic [7:0] SLEEP_SUPPLY_RST    = 8'h00;
  localparam logic [7:0] SHUTDOWN_CHARGE_RST = 8'h05;
  localparam logic [7:0] SERIAL_FORMAT_RST   = 8'h30;
  // Read-only reserved bits are dropped on write and read as zero
  localparam logic [7:0] SLEEP_SUPPLY_WMASK    = 8'hFD;
  localparam logic [7:0] SHUTDOWN_CHARGE_WMASK = 8'h3F;
  localparam logic [7:0] SERIAL_FORMAT_WMASK   = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ         = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SUPPLY_SEL_BIT    = 7;
  localparam int REF_TIME_LSB      = 3;
  localparam int BROADCAST_BIT     = 2;
  localparam int WAKE_BIT          = 0;
  localparam int INCAP_TIME_LSB    = 4;
  localparam int PROTO_LSB         = 6;
  localparam int WLEN_LSB          = 4;
  localparam int FSYNC_INV_BIT     = 3;
  localparam int BCLK_INV_BIT      = 2;
  localparam int TX_EDGE_BIT       = 1;
  localparam int TX_FILL_BIT       = 0;

  // ****************************************
  // Control bus constants
  // ****************************************
  localparam logic [6:0] BROADCAST_ADDR = 7'h4C;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [2:0] MSB_INDEX      = 3'h7;

  // ****************************************
  // Encodings and typical charge times in microseconds
  // ****************************************
  localparam logic [1:0] PROTO_TDM      = 2'h0;
  localparam logic [1:0] PROTO_I2S      = 2'h1;
  localparam logic [1:0] PROTO_LJ       = 2'h2;
  localparam logic [1:0] PROTO_RESERVED = 2'h3;
  localparam logic [5:0] WLEN_BITS_0    = 6'h10;
  localparam logic [5:0] WLEN_BITS_1    = 6'h14;
  localparam logic [5:0] WLEN_BITS_2    = 6'h18;
  localparam logic [5:0] WLEN_BITS_3    = 6'h20;
  localparam logic [16:0] REF_TIME_US_0   = 17'h00DAC;
  localparam logic [16:0] REF_TIME_US_1   = 17'h02710;
  localparam logic [16:0] REF_TIME_US_2   = 17'h0C350;
  localparam logic [16:0] REF_TIME_US_3   = 17'h186A0;
  localparam logic [16:0] INCAP_TIME_US_0 = 17'h009C4;
  localparam logic [16:0] INCAP_TIME_US_1 = 17'h030D4;
  localparam logic [16:0] INCAP_TIME_US_2 = 17'h061A8;
  localparam logic [16:0] INCAP_TIME_US_3 = 17'h0C350;

  // Control bus slave states, one-hot
  typedef enum logic [6:0] {
    PSFC_IDLE     = 7'h01,
    PSFC_ADDR     = 7'h02,
    PSFC_ADDR_ACK = 7'h04,
    PSFC_WDATA    = 7'h08,
    PSFC_WACK     = 7'h10,
    PSFC_RDATA    = 7'h20,
    PSFC_RACK     = 7'h40
  } psfc_state_t;

endpackage : psfc_pkg

/* psfc_config_bank.sv */
// Configuration bank with its two-wire control bus slave.
// Assumes scl, sda and the address straps are asynchronous pins and the
// serial clock and frame pins are only passed through, never sampled.
`timescale 1ns/10ps
`default_nettype none

module psfc_config_bank
  import psfc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [6:0]  devAddrPin,
  input  wire logic        frameSyncRaw,
  input  wire logic        bitClockRaw,
  input  wire logic        slotActive,
  output logic             frameSyncOut,
  output logic             bitClockOut,
  output logic             launchOnRising,
  output logic             dataOutEnable,
  output logic             analogSupplySourceSel,
  output logic [1:0]       referencePrechargeTime,
  output logic [16:0]      refChargeTimeUs,
  output logic             broadcastAddressingOn,
  output logic             wakeNSleep,
  output logic             deviceAsleep,
  output logic [1:0]       inputCapPrechargeTime,
  output logic [16:0]      inCapChargeTimeUs,
  output logic [1:0]       serialProtocolSel,
  output logic             protocolReserved,
  output logic [1:0]       serialWordLength,
  output logic [5:0]       wordBits,
  output logic             frameSyncInvert,
  output logic             bitClockInvert,
  output logic             txEdge,
  output logic             txFill
);

  // ****************************************
  // Decode functions
  // ****************************************
  function automatic logic [7:0] readReg(input logic [7:0] ofs, input logic [7:0] slp,
                                         input logic [7:0] shd, input logic [7:0] ser);
    case (ofs)
      SLEEP_SUPPLY_OFS:    readReg = slp & SLEEP_SUPPLY_WMASK;
      SHUTDOWN_CHARGE_OFS: readReg = shd & SHUTDOWN_CHARGE_WMASK;
      SERIAL_FORMAT_OFS:   readReg = ser;
      default:             readReg = UNMAPPED_READ;
    endcase
  endfunction : readReg

  function automatic logic [16:0] timeOf(input logic [1:0] code, input logic [16:0] t0,
                                         input logic [16:0] t1, input logic [16:0] t2,
                                         input logic [16:0] t3);
    case (code)
      2'h0:    timeOf = t0;
      2'h1:    timeOf = t1;
      2'h2:    timeOf = t2;
      default: timeOf = t3;
    endcase
  endfunction : timeOf

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  sleepSupply;
  logic [7:0]  shutdownCharge;
  logic [7:0]  serialFormat;
  logic [7:0]  next_sleepSupply;
  logic [7:0]  next_shutdownCharge;
  logic [7:0]  next_serialFormat;
  psfc_state_t state;
  psfc_state_t next_state;
  logic [3:0]  bitCnt;
  logic [3:0]  next_bitCnt;
  logic [7:0]  shiftIn;
  logic [7:0]  next_shiftIn;
  logic [7:0]  txByte;
  logic [7:0]  next_txByte;
  logic [7:0]  regPtr;
  logic [7:0]  next_regPtr;
  logic        readMode;
  logic        next_readMode;
  logic        ptrPhase;
  logic        next_ptrPhase;
  logic        hostNack;
  logic        next_hostNack;
  logic        sdaLow;
  logic        next_sdaLow;
  logic        sclS1;
  logic        sclS2;
  logic        sclD;
  logic        sdaS1;
  logic        sdaS2;
  logic        sdaD;
  logic [6:0]  addrS1;
  logic [6:0]  addrS2;
  logic        sclRise;
  logic        sclFall;
  logic        busStart;
  logic        busStop;
  logic        addrHit;
  logic [7:0]  curRead;

  // Pin synchronisers; the second stage feeds logic, with a one-cycle delayed copy for scl and sda only
  always_ff @(posedge sys_clk) begin
    sclS1  <= scl;
    sclS2  <= sclS1;
    sclD   <= sclS2;
    sdaS1  <= sdaIn;
    sdaS2  <= sdaS1;
    sdaD   <= sdaS2;
    addrS1 <= devAddrPin;
    addrS2 <= addrS1;
  end

  // Bus events seen on synchronised levels
  assign sclRise  = sclS2 & ~sclD;
  assign sclFall  = ~sclS2 & sclD;
  assign busStart = sclS2 & sclD & sdaD & ~sdaS2;
  assign busStop  = sclS2 & sclD & ~sdaD & sdaS2;
  assign addrHit  = (shiftIn[7:1] == addrS2) ||
                    (sleepSupply[BROADCAST_BIT] && shiftIn[7:1] == BROADCAST_ADDR);
  assign curRead  = readReg(regPtr, sleepSupply, shutdownCharge, serialFormat);

  // ****************************************
  // Next-state logic: bus slave and register writes
  // ****************************************
  always_comb begin
    next_state          = state;
    next_bitCnt         = bitCnt;
    next_shiftIn        = shiftIn;
    next_txByte         = txByte;
    next_regPtr         = regPtr;
    next_readMode       = readMode;
    next_ptrPhase       = ptrPhase;
    next_hostNack       = hostNack;
    next_sdaLow         = sdaLow;
    next_sleepSupply    = sleepSupply;
    next_shutdownCharge = shutdownCharge;
    next_serialFormat   = serialFormat;
    if (busStop) begin
      next_state  = PSFC_IDLE;
      next_sdaLow = 1'b0;
    end else if (busStart) begin
      // Repeated start keeps the register pointer for write-then-read
      next_state  = PSFC_ADDR;
      next_bitCnt = 4'h0;
      next_sdaLow = 1'b0;
    end else begin
      case (state)
        PSFC_ADDR, PSFC_WDATA: begin
          if (sclRise && bitCnt < BYTE_BITS) begin
            next_shiftIn = {shiftIn[6:0], sdaS2};
            next_bitCnt  = bitCnt + 4'h1;
          end else if (sclFall && bitCnt == BYTE_BITS) begin
            next_bitCnt = 4'h0;
            if (state == PSFC_ADDR) begin
              // Foreign address: stay silent until the next start
              next_state    = addrHit ? PSFC_ADDR_ACK : PSFC_IDLE;
              next_sdaLow   = addrHit;
              next_readMode = shiftIn[0];
            end else begin
              next_state  = PSFC_WACK;
              next_sdaLow = 1'b1;
              if (ptrPhase) begin
                next_regPtr = shiftIn;
              end else begin
                next_regPtr = regPtr + 8'h01;
                case (regPtr)
                  SLEEP_SUPPLY_OFS:    next_sleepSupply = shiftIn & SLEEP_SUPPLY_WMASK;
                  SHUTDOWN_CHARGE_OFS: next_shutdownCharge = shiftIn & SHUTDOWN_CHARGE_WMASK;
                  SERIAL_FORMAT_OFS:   next_serialFormat = shiftIn & SERIAL_FORMAT_WMASK;
                  default:             next_regPtr = regPtr + 8'h01;
                endcase
              end
            end
          end
        end
        PSFC_ADDR_ACK, PSFC_RACK: begin
          if (sclRise) begin
            next_hostNack = sdaS2;
          end else if (sclFall) begin
            next_bitCnt = 4'h0;
            if (state == PSFC_RACK && hostNack) begin
              next_state  = PSFC_IDLE;
              next_sdaLow = 1'b0;
            end else if (readMode) begin
              next_state  = PSFC_RDATA;
              next_txByte = curRead;
              next_sdaLow = ~curRead[MSB_INDEX];
            end else begin
              next_state    = PSFC_WDATA;
              next_ptrPhase = 1'b1;
              next_sdaLow   = 1'b0;
            end
          end
        end
        PSFC_WACK: begin
          if (sclFall) begin
            next_state    = PSFC_WDATA;
            next_ptrPhase = 1'b0;
            next_sdaLow   = 1'b0;
          end
        end
        PSFC_RDATA: begin
          if (sclRise) begin
            next_bitCnt = bitCnt + 4'h1;
          end else if (sclFall) begin
            if (bitCnt == BYTE_BITS) begin
              next_state  = PSFC_RACK;
              next_sdaLow = 1'b0;
              next_regPtr = regPtr + 8'h01;
            end else begin
              next_sdaLow = ~txByte[MSB_INDEX - bitCnt[2:0]];
            end
          end
        end
        default: begin // Idle rests here, stray codes fall back to it
          next_state  = PSFC_IDLE;
          next_sdaLow = 1'b0;
        end
      endcase
    end
  end

  // Registered state; reset gives documented register values
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state          <= PSFC_IDLE;
      bitCnt         <= 4'h0;
      shiftIn        <= 8'h00;
      txByte         <= 8'h00;
      regPtr         <= 8'h00;
      readMode       <= 1'b0;
      ptrPhase       <= 1'b0;
      hostNack       <= 1'b0;
      sdaLow         <= 1'b0;
      sleepSupply    <= SLEEP_SUPPLY_RST;
      shutdownCharge <= SHUTDOWN_CHARGE_RST;
      serialFormat   <= SERIAL_FORMAT_RST;
    end else begin
      state          <= next_state;
      bitCnt         <= next_bitCnt;
      shiftIn        <= next_shiftIn;
      txByte         <= next_txByte;
      regPtr         <= next_regPtr;
      readMode       <= next_readMode;
      ptrPhase       <= next_ptrPhase;
      hostNack       <= next_hostNack;
      sdaLow         <= next_sdaLow;
      sleepSupply    <= next_sleepSupply;
      shutdownCharge <= next_shutdownCharge;
      serialFormat   <= next_serialFormat;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open-drain data line: only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaLow;

  // Field views of the registers
  assign analogSupplySourceSel  = sleepSupply[SUPPLY_SEL_BIT];
  assign referencePrechargeTime = sleepSupply[REF_TIME_LSB +: 2];
  assign refChargeTimeUs        = timeOf(referencePrechargeTime, REF_TIME_US_0,
                                         REF_TIME_US_1, REF_TIME_US_2, REF_TIME_US_3);
  assign broadcastAddressingOn  = sleepSupply[BROADCAST_BIT];
  assign wakeNSleep             = sleepSupply[WAKE_BIT];
  assign deviceAsleep           = ~sleepSupply[WAKE_BIT];
  assign inputCapPrechargeTime  = shutdownCharge[INCAP_TIME_LSB +: 2];
  assign inCapChargeTimeUs      = timeOf(inputCapPrechargeTime, INCAP_TIME_US_0,
                                         INCAP_TIME_US_1, INCAP_TIME_US_2,
                                         INCAP_TIME_US_3);
  assign serialProtocolSel      = serialFormat[PROTO_LSB +: 2];
  assign protocolReserved       = (serialProtocolSel == PROTO_RESERVED);
  assign serialWordLength       = serialFormat[WLEN_LSB +: 2];
  assign wordBits               = (serialWordLength == 2'h0) ? WLEN_BITS_0 :
                                  (serialWordLength == 2'h1) ? WLEN_BITS_1 :
                                  (serialWordLength == 2'h2) ? WLEN_BITS_2 :
                                  WLEN_BITS_3;
  assign frameSyncInvert        = serialFormat[FSYNC_INV_BIT];
  assign bitClockInvert         = serialFormat[BCLK_INV_BIT];
  assign txEdge                 = serialFormat[TX_EDGE_BIT];
  assign txFill                 = serialFormat[TX_FILL_BIT];
  // Pass-through polarity; combinational so the clock path gains no latency
  assign frameSyncOut   = frameSyncRaw ^ frameSyncInvert;
  assign bitClockOut    = bitClockRaw ^ bitClockInvert;
  // Standard launch is the falling edge; each invert moves it half a cycle
  assign launchOnRising = bitClockInvert ^ txEdge;
  // Unused cycles drive zero unless released to high impedance
  assign dataOutEnable  = slotActive | ~txFill;
endmodule : psfc_config_bank
`default_nettype wire

/* psfc_config_bank_props.sv */
// Port checker for the configuration bank.
// Assumes the bind below and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module psfc_config_bank_props
  import psfc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       sdaOe,
  input wire logic       frameSyncRaw,
  input wire logic       bitClockRaw,
  input wire logic       slotActive,
  input wire logic       frameSyncOut,
  input wire logic       bitClockOut,
  input wire logic       launchOnRising,
  input wire logic       dataOutEnable,
  input wire logic       wakeNSleep,
  input wire logic       deviceAsleep,
  input wire logic [1:0] inputCapPrechargeTime,
  input wire logic [1:0] serialProtocolSel,
  input wire logic       protocolReserved,
  input wire logic [1:0] serialWordLength,
  input wire logic [5:0] wordBits,
  input wire logic       frameSyncInvert,
  input wire logic       bitClockInvert,
  input wire logic       txEdge,
  input wire logic       txFill
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_FS_INV: assert property (frameSyncOut == (frameSyncRaw ^ frameSyncInvert))
    else $error("frame sync polarity wrong");
  AST_BC_INV: assert property (bitClockOut == (bitClockRaw ^ bitClockInvert))
    else $error("bit clock polarity wrong");
  AST_LAUNCH: assert property (launchOnRising == (bitClockInvert ^ txEdge))
    else $error("launch edge wrong");
  AST_FILL: assert property (dataOutEnable == (slotActive | !txFill))
    else $error("unused cycle fill wrong");
  AST_ASLEEP: assert property (deviceAsleep == !wakeNSleep)
    else $error("sleep state wrong");
  AST_RSV: assert property (protocolReserved == (serialProtocolSel == 2'h3))
    else $error("reserved protocol flag wrong");
  AST_WLEN: assert property (wordBits == ((serialWordLength == 2'h3) ? 6'h20 :
    6'h10 + {2'h0, serialWordLength, 2'h0})) else $error("word bits wrong");
  // Fields may only move at a bus acknowledge
  AST_HOLD: assert property ($changed({serialProtocolSel, serialWordLength,
    txFill, wakeNSleep}) |-> ##[0:4] sdaOe) else $error("field moved without write");
  AST_RST: assert property (disable iff (1'b0) !rstn |=> !sdaOe && !wakeNSleep &&
    serialWordLength == 2'h3 && inputCapPrechargeTime == 2'h0)
    else $error("reset values wrong");
endmodule : psfc_config_bank_props
bind psfc_config_bank psfc_config_bank_props u_props (
  .sys_clk(sys_clk), .rstn(rstn), .sdaOe(sdaOe), .frameSyncRaw(frameSyncRaw),
  .bitClockRaw(bitClockRaw), .slotActive(slotActive), .frameSyncOut(frameSyncOut),
  .bitClockOut(bitClockOut), .launchOnRising(launchOnRising), .dataOutEnable(dataOutEnable),
  .wakeNSleep(wakeNSleep), .deviceAsleep(deviceAsleep),
  .inputCapPrechargeTime(inputCapPrechargeTime), .serialProtocolSel(serialProtocolSel),
  .protocolReserved(protocolReserved), .serialWordLength(serialWordLength),
  .wordBits(wordBits), .frameSyncInvert(frameSyncInvert), .bitClockInvert(bitClockInvert),
  .txEdge(txEdge), .txFill(txFill));
`default_nettype wire

/* psfc_host_model.sv */
// Two-wire bus host driving the bank's control pins.
// Assumes a pulled-up open-drain data line; acts on falling edges.
`timescale 1ns/10ps
`default_nettype none
module psfc_host_model (
  input  wire logic sys_clk,
  input  wire logic sdaOe,
  output logic      scl,
  output logic      sdaIn
);
  logic hostLow;
  // Pull-up wins unless either party pulls low
  assign sdaIn = ~(hostLow | sdaOe);
  initial begin
    scl = 1'b1;
    hostLow = 1'b0;
  end
  // Six cycles keeps both phases above the four-cycle minimum
  task automatic gap();
    repeat (6) @(negedge sys_clk);
  endtask : gap
  task automatic put(input logic b);
    @(negedge sys_clk);
    hostLow = ~b;
    gap();
    scl = 1'b1;
    gap();
    scl = 1'b0;
  endtask : put
  task automatic get(output logic b);
    @(negedge sys_clk);
    hostLow = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    b = sdaIn;
    scl = 1'b0;
  endtask : get
  task automatic start();
    @(negedge sys_clk);
    hostLow = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    hostLow = 1'b1;
    gap();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    @(negedge sys_clk);
    hostLow = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    hostLow = 1'b0;
    gap();
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ack = ~a;
  endtask : send
  task automatic wr(input logic [6:0] ad, input logic [7:0] ofs, input logic [7:0] dat,
                    output logic ok);
    logic k1, k2, k3;
    start();
    send({ad, 1'b0}, k1);
    send(ofs, k2);
    send(dat, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask : wr
  // Single-byte read ends with a host refusal
  task automatic rd(input logic [6:0] ad, input logic [7:0] ofs, output logic [7:0] d);
    logic k;
    start();
    send({ad, 1'b0}, k);
    send(ofs, k);
    start();
    send({ad, 1'b1}, k);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop();
  endtask : rd
endmodule : psfc_host_model
`default_nettype wire

/* power_and_serial_format_config_tb.sv */
// Self-checking bench for the configuration bank.
// Assumes psfc_host_model stands in for the bus host.
`timescale 1ns/10ps
`default_nettype none
module power_and_serial_format_config_tb
  import psfc_pkg::*;
;
  localparam logic [6:0] OWN_ADDR = 7'h18;
  logic        sys_clk, rstn, scl, sdaIn, sdaOut, sdaOe, frameSyncRaw, bitClockRaw;
  logic        slotActive, frameSyncOut, bitClockOut, launchOnRising, dataOutEnable;
  logic        analogSupplySourceSel, broadcastAddressingOn, wakeNSleep, deviceAsleep;
  logic        frameSyncInvert, bitClockInvert, txEdge, txFill, protocolReserved;
  logic [1:0]  referencePrechargeTime, inputCapPrechargeTime;
  logic [1:0]  serialProtocolSel, serialWordLength;
  logic [5:0]  wordBits;
  logic [6:0]  devAddrPin;
  logic [16:0] refChargeTimeUs, inCapChargeTimeUs;
  int          bad_count, samples_checked, cycles;
  logic [16:0] refT [4] = '{17'h00DAC, 17'h02710, 17'h0C350, 17'h186A0};
  logic [16:0] incT [4] = '{17'h009C4, 17'h030D4, 17'h061A8, 17'h0C350};

  psfc_config_bank DUT (
    .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .devAddrPin(devAddrPin), .frameSyncRaw(frameSyncRaw), .bitClockRaw(bitClockRaw),
    .slotActive(slotActive), .frameSyncOut(frameSyncOut), .bitClockOut(bitClockOut),
    .launchOnRising(launchOnRising), .dataOutEnable(dataOutEnable),
    .analogSupplySourceSel(analogSupplySourceSel),
    .referencePrechargeTime(referencePrechargeTime), .refChargeTimeUs(refChargeTimeUs),
    .broadcastAddressingOn(broadcastAddressingOn), .wakeNSleep(wakeNSleep),
    .deviceAsleep(deviceAsleep), .inputCapPrechargeTime(inputCapPrechargeTime),
    .inCapChargeTimeUs(inCapChargeTimeUs), .serialProtocolSel(serialProtocolSel),
    .protocolReserved(protocolReserved), .serialWordLength(serialWordLength),
    .wordBits(wordBits), .frameSyncInvert(frameSyncInvert), .bitClockInvert(bitClockInvert),
    .txEdge(txEdge), .txFill(txFill));
  psfc_host_model HOST (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ****
  // Checking helpers
  // ****
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    HOST.rd(OWN_ADDR, ofs, d);
    check(d, exp);
  endtask : rdchk
  task automatic wrchk(input logic [7:0] ofs, input logic [7:0] v);
    logic ok;
    HOST.wr(OWN_ADDR, ofs, v, ok);
    check(ok, 1'b1);
  endtask : wrchk
  task automatic test_done();
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    check(wordBits, 6'h20);
    check(deviceAsleep, 1'b1);
    check({refChargeTimeUs, inCapChargeTimeUs} == {refT[0], incT[0]}, 1'b1);
    rdchk(8'h02, 8'h00);
    rdchk(8'h05, 8'h05);
    rdchk(8'h07, 8'h30);
  endtask : t_reset
  task automatic t_sleep();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[0], 2'h0, i[1:0], i[1], 1'b0, ~i[0]};
      wrchk(8'h02, v);
      check(analogSupplySourceSel, i[0]);
      check(refChargeTimeUs, refT[i]);
      check(referencePrechargeTime, i[1:0]);
      check(broadcastAddressingOn, i[1]);
      check(deviceAsleep, i[0]);
      check(wakeNSleep, !i[0]);
      rdchk(8'h02, v);
    end
  endtask : t_sleep
  task automatic t_incap();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {2'h0, i[1:0], 4'h5};
      wrchk(8'h05, v);
      check(inCapChargeTimeUs, incT[i]);
      check(inputCapPrechargeTime, i[1:0]);
      rdchk(8'h05, v);
    end
  endtask : t_incap
  // Twelve mixes of protocols 0 to 2, lengths and flags, each with all raw pin levels
  task automatic t_format();
    logic [7:0] v;
    for (int i = 0; i < 12; i++) begin
      // Protocol code 3 is never sent; length code 0 is the 16-bit host choice
      v = {2'(i % 3), 2'(i % 4), i[3:0]};
      wrchk(8'h07, v);
      check(serialProtocolSel, v[7:6]);
      check(protocolReserved, 1'b0);
      check({serialWordLength, frameSyncInvert, bitClockInvert, txEdge, txFill}, v[5:0]);
      check(wordBits, (v[5:4] == 2'h3) ? 6'h20 : 6'h10 + 6'(v[5:4]) * 6'h4);
      check(launchOnRising, v[2] ^ v[1]);
      for (int j = 0; j < 8; j++) begin
        {frameSyncRaw, bitClockRaw, slotActive} = j[2:0];
        @(negedge sys_clk);
        check(frameSyncOut, j[2] ^ v[3]);
        check(bitClockOut, j[1] ^ v[2]);
        check(dataOutEnable, j[0] | !v[0]);
      end
      rdchk(8'h07, v);
    end
  endtask : t_format
  // Fixed address refused until enabled; unmapped place reads zero
  task automatic t_bcast();
    logic ok;
    wrchk(8'h02, 8'h01);
    HOST.wr(7'h4C, 8'h07, 8'h40, ok);
    check(ok, 1'b0);
    check(sdaOut, 1'b0);
    rdchk(8'h07, 8'hBB);
    wrchk(8'h02, 8'h05);
    HOST.wr(7'h4C, 8'h07, 8'h50, ok);
    check(ok, 1'b1);
    rdchk(8'h07, 8'h50);
    wrchk(8'h03, 8'hA5);
    rdchk(8'h03, 8'h00);
    rdchk(8'h02, 8'h05);
  endtask : t_bcast
  task automatic do_reset();
    rstn = 1'b0;
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : do_reset
  // Hang guard well above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    {frameSyncRaw, bitClockRaw, slotActive} = 3'h0;
    devAddrPin = OWN_ADDR;
    do_reset();
    t_reset();
    t_sleep();
    t_incap();
    t_format();
    t_bcast();
    do_reset();
    t_reset();
    test_done();
  end
endmodule : power_and_serial_format_config_tb
`default_nettype wire
